// *** verilog/pvsc_top.sv ***
// Vendor register bank of one transceiver port: pulse state view, user word,
// receive error counter and device status flags.
// Assumes register accesses and event pulses are on i_clock; state levels are
// asynchronous and are synchronised here.
`timescale 1ns/10ps

module pvsc_top
    import pvsc_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst_b,
    // Register access from the management frame engine
    input  wire logic [4:0]  i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [15:0] i_reg_wdata,
    output logic      [15:0] o_reg_rdata,
    // Autonegotiation state levels
    input  wire logic [12:0] i_arb_states,
    input  wire logic [3:0]  i_flp_rx_busy_states,
    input  wire logic [2:0]  i_flp_rx_states,
    input  wire logic [5:0]  i_nlp_rx_states,
    input  wire logic [5:0]  i_flp_tx_states,
    // Link levels
    input  wire logic        i_speed_100,
    input  wire logic        i_fast_link_up,
    input  wire logic        i_slow_link_up,
    input  wire logic        i_polarity_reversed,
    input  wire logic        i_polarity_fix_enable,
    // Event pulses
    input  wire logic        i_rx_error_event,
    input  wire logic        i_false_carrier_event,
    input  wire logic        i_link_drop_event,
    input  wire logic        i_missing_sfd_event,
    input  wire logic        i_code_violation_event,
    input  wire logic        i_scrambler_unlock_event,
    input  wire logic        i_jam_event,
    // Receive data path
    input  wire logic        i_rx_raw_bit,
    input  wire logic [3:0]  i_rx_nibble,
    output logic             o_rx_corrected_bit,
    output logic      [3:0]  o_rx_nibble_lines,
    // User output
    output logic      [15:0] o_user_word_bus
);

    // ========================================
    // Decode helper
    function automatic logic reg_hit(input logic [4:0] addr, input logic [4:0] offset);
        reg_hit = (addr == offset);
    endfunction

    // ========================================
    // Level synchronisers: first stage feeds only the second
    logic [PVSC_SYNC_WIDTH-1:0] sync_meta;
    logic [PVSC_SYNC_WIDTH-1:0] sync_level;
    logic [PVSC_SYNC_WIDTH-1:0] raw_level;

    assign raw_level = {i_arb_states, i_flp_rx_busy_states, i_flp_rx_states, i_nlp_rx_states,
                        i_flp_tx_states, i_speed_100, i_fast_link_up, i_slow_link_up,
                        i_polarity_reversed, i_polarity_fix_enable};

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sync_meta  <= '0;
            sync_level <= '0;
        end
        else
        begin
            sync_meta  <= raw_level;
            sync_level <= sync_meta;
        end
    end

    logic [12:0] arb_states;
    logic [3:0]  flp_rx_busy;
    logic [2:0]  flp_rx_states;
    logic [5:0]  nlp_rx_states;
    logic [5:0]  flp_tx_states;
    logic        speed_100;
    logic        fast_link_up;
    logic        slow_link_up;
    logic        polarity_reversed;
    logic        polarity_fix_enable;

    assign {arb_states, flp_rx_busy, flp_rx_states, nlp_rx_states, flp_tx_states, speed_100,
            fast_link_up, slow_link_up, polarity_reversed, polarity_fix_enable} = sync_level;

    // ========================================
    // Access strobes
    logic rd_count;
    logic rd_status;
    logic wr_user;
    logic wr_count;

    assign rd_count  = i_reg_rd && reg_hit(i_reg_addr, PVSC_ADDR_ERR_COUNT);
    assign rd_status = i_reg_rd && reg_hit(i_reg_addr, PVSC_ADDR_STATUS);
    assign wr_user   = i_reg_wr && reg_hit(i_reg_addr, PVSC_ADDR_USER_WORD);
    assign wr_count  = i_reg_wr && reg_hit(i_reg_addr, PVSC_ADDR_ERR_COUNT);

    // ========================================
    // Latched status flags, each gated by the speed it belongs to
    logic [PVSC_LATCH_COUNT-1:0] latch_set;
    logic [PVSC_LATCH_COUNT-1:0] latch_flags;

    always_comb
    begin
        latch_set                      = '0;
        latch_set[PVSC_LF_MISSING_SFD] = i_missing_sfd_event && !speed_100;
        latch_set[PVSC_LF_CODE_VIOL]   = i_code_violation_event && !speed_100;
        latch_set[PVSC_LF_LINK_DROP]   = i_link_drop_event && speed_100;
        latch_set[PVSC_LF_UNLOCKED]    = i_scrambler_unlock_event && speed_100;
        latch_set[PVSC_LF_FALSE_CARR]  = i_false_carrier_event && speed_100;
        latch_set[PVSC_LF_JAM]         = i_jam_event && speed_100;
    end

    pvsc_latch_bank #(
        .WIDTH   (PVSC_LATCH_COUNT)
    ) u_latch_bank (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .i_set   (latch_set),
        .i_clear (rd_status),
        .o_flags (latch_flags)
    );

    // ========================================
    // User word, counter mode and error counter
    logic [15:0] user_word;
    logic [15:0] next_user_word;
    logic        split_mode;
    logic        next_split_mode;
    logic [15:0] err_count;
    logic [15:0] next_err_count;

    // Read clears first, so an event in the same cycle lands in the fresh count
    always_comb
    begin
        logic [15:0] base;
        base            = rd_count ? PVSC_COUNT_RST : err_count;
        next_user_word  = wr_user ? i_reg_wdata : user_word;
        next_split_mode = wr_count ? i_reg_wdata[PVSC_MODE_BIT] : split_mode;
        if (!split_mode)
            next_err_count = 16'(base + {15'h0000, i_rx_error_event});
        else
        begin
            // Fields wrap independently; a carry never spills into a neighbour
            next_err_count[PVSC_RXERR_MSB:0] =
                8'(base[PVSC_RXERR_MSB:0] + {7'h00, i_rx_error_event});
            next_err_count[PVSC_FCAR_MSB:PVSC_FCAR_LSB] =
                4'(base[PVSC_FCAR_MSB:PVSC_FCAR_LSB] + {3'h0, i_false_carrier_event});
            next_err_count[PVSC_DROP_MSB:PVSC_DROP_LSB] =
                4'(base[PVSC_DROP_MSB:PVSC_DROP_LSB] + {3'h0, i_link_drop_event});
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            user_word  <= PVSC_USER_WORD_RST;
            split_mode <= PVSC_SPLIT_MODE_RST;
            err_count  <= PVSC_COUNT_RST;
        end
        else
        begin
            user_word  <= next_user_word;
            split_mode <= next_split_mode;
            err_count  <= next_err_count;
        end
    end

    assign o_user_word_bus = user_word;

    // ========================================
    // Read data; the counter view never shows the mode bit
    logic [15:0] status_word;
    logic [15:0] next_rdata;

    always_comb
    begin
        status_word                      = '0;
        status_word[PVSC_ST_MISSING_SFD] = latch_flags[PVSC_LF_MISSING_SFD];
        status_word[PVSC_ST_CODE_VIOL]   = latch_flags[PVSC_LF_CODE_VIOL];
        status_word[PVSC_ST_POLARITY]    = polarity_fix_enable && polarity_reversed;
        status_word[PVSC_ST_LINK_DROP]   = latch_flags[PVSC_LF_LINK_DROP];
        status_word[PVSC_ST_UNLOCKED]    = latch_flags[PVSC_LF_UNLOCKED];
        status_word[PVSC_ST_FALSE_CARR]  = latch_flags[PVSC_LF_FALSE_CARR];
        status_word[PVSC_ST_JAM]         = latch_flags[PVSC_LF_JAM];
        status_word[PVSC_ST_FAST_UP]     = fast_link_up;
        status_word[PVSC_ST_SLOW_UP]     = slow_link_up;
        next_rdata = o_reg_rdata;
        if (i_reg_rd)
        begin
            unique case (i_reg_addr)
                PVSC_ADDR_ARB_VIEW:   next_rdata = {3'h0, arb_states};
                PVSC_ADDR_PULSE_VIEW: next_rdata = {|flp_rx_busy, flp_rx_states,
                                                    nlp_rx_states, flp_tx_states};
                PVSC_ADDR_USER_WORD:  next_rdata = user_word;
                PVSC_ADDR_ERR_COUNT:  next_rdata = err_count;
                PVSC_ADDR_STATUS:     next_rdata = status_word;
                default:              next_rdata = 16'h0000;
            endcase
        end
    end

    // ========================================
    // Receive path: polarity fix and error code substitution
    logic       next_rx_bit;
    logic [3:0] next_nibble;

    always_comb
    begin
        next_rx_bit = i_rx_raw_bit ^ (polarity_fix_enable && polarity_reversed);
        // Code only shown in 10 Mbit/s, where the violation is meaningful
        next_nibble = (i_code_violation_event && !speed_100) ? PVSC_CODE_VIOL_NIBBLE : i_rx_nibble;
    end

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_reg_rdata        <= 16'h0000;
            o_rx_corrected_bit <= 1'b0;
            o_rx_nibble_lines  <= PVSC_NIBBLE_RST;
        end
        else
        begin
            o_reg_rdata        <= next_rdata;
            o_rx_corrected_bit <= next_rx_bit;
            o_rx_nibble_lines  <= next_nibble;
        end
    end

    // ========================================
    // Checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    user_bus_a: assert property (wr_user |=> o_user_word_bus == $past(i_reg_wdata))
        else $error("user bus does not follow the written word");
    mode_write_a: assert property (wr_count |=> split_mode == $past(i_reg_wdata[0]))
        else $error("counter mode not taken from write");
    count_16_a: assert property ((!split_mode && !rd_count && i_rx_error_event) |=>
        err_count == 16'($past(err_count) + 16'h0001))
        else $error("16-bit count missed a receive error");
    read_clear_a: assert property ((rd_count && !i_rx_error_event && !i_false_carrier_event
        && !i_link_drop_event) |=> (err_count == 16'h0000))
        else $error("counter not cleared by read");
    split_carrier_a: assert property ((split_mode && !rd_count && i_false_carrier_event) |=>
        err_count[11:8] == 4'($past(err_count[11:8]) + 4'h1))
        else $error("false carrier field did not count");
    split_drop_a: assert property ((split_mode && !rd_count && i_link_drop_event) |=>
        err_count[15:12] == 4'($past(err_count[15:12]) + 4'h1))
        else $error("link drop field did not count");
    flp_busy_a: assert property ((i_reg_rd && i_reg_addr == PVSC_ADDR_PULSE_VIEW) |=>
        o_reg_rdata[15] == (|$past(flp_rx_busy)))
        else $error("pulse receive busy bit wrong");
    read_keeps_a: assert property ((rd_count && !split_mode && i_rx_error_event) |=>
        err_count == 16'h0001)
        else $error("event lost during clearing read");
    nibble_code_a: assert property ((i_code_violation_event && !speed_100) |=>
        o_rx_nibble_lines == PVSC_CODE_VIOL_NIBBLE)
        else $error("code violation nibble missing");
    polarity_fix_a: assert property ((polarity_fix_enable && polarity_reversed) |=>
        o_rx_corrected_bit == !$past(i_rx_raw_bit))
        else $error("reversed polarity not corrected");

    // Views and holds; the bus must not drift between writes
    user_hold_a: assert property (!wr_user |=> $stable(o_user_word_bus))
        else $error("user bus changed without a write");
    count_view_a: assert property ((i_reg_rd && i_reg_addr == PVSC_ADDR_ERR_COUNT) |=>
        o_reg_rdata == $past(err_count))
        else $error("counter read shows more than the count");
    link_bits_a: assert property ((i_reg_rd && i_reg_addr == PVSC_ADDR_STATUS) |=>
        o_reg_rdata[1:0] == $past({fast_link_up, slow_link_up}))
        else $error("link up bits wrong in status read");

endmodule

// *** verilog/pvsc_pkg.sv ***
// Package for the vendor status and counter register bank of one port.
// Assumes a management frame engine outside that hands over parallel register accesses.
package pvsc_pkg;

    // ========================================
    // Register addresses on the management bus
    localparam logic [4:0]  PVSC_ADDR_ARB_VIEW   = 5'h11;
    localparam logic [4:0]  PVSC_ADDR_PULSE_VIEW = 5'h12;
    localparam logic [4:0]  PVSC_ADDR_USER_WORD  = 5'h14;
    localparam logic [4:0]  PVSC_ADDR_ERR_COUNT  = 5'h15;
    localparam logic [4:0]  PVSC_ADDR_STATUS     = 5'h1c;

    // ========================================
    // Reset values
    localparam logic [15:0] PVSC_USER_WORD_RST   = 16'h0000;
    localparam logic [15:0] PVSC_COUNT_RST       = 16'h0000;
    localparam logic        PVSC_SPLIT_MODE_RST  = 1'b0;
    localparam logic [3:0]  PVSC_NIBBLE_RST      = 4'h0;

    // ========================================
    // Counter field layout
    localparam int          PVSC_MODE_BIT        = 0;
    localparam int          PVSC_RXERR_MSB       = 7;
    localparam int          PVSC_FCAR_LSB        = 8;
    localparam int          PVSC_FCAR_MSB        = 11;
    localparam int          PVSC_DROP_LSB        = 12;
    localparam int          PVSC_DROP_MSB        = 15;

    // ========================================
    // Status register bit positions
    localparam int          PVSC_ST_MISSING_SFD  = 8;
    localparam int          PVSC_ST_CODE_VIOL    = 7;
    localparam int          PVSC_ST_POLARITY     = 6;
    localparam int          PVSC_ST_LINK_DROP    = 5;
    localparam int          PVSC_ST_UNLOCKED     = 4;
    localparam int          PVSC_ST_FALSE_CARR   = 3;
    localparam int          PVSC_ST_JAM          = 2;
    localparam int          PVSC_ST_FAST_UP      = 1;
    localparam int          PVSC_ST_SLOW_UP      = 0;

    // ========================================
    // Latched flag bank indexes
    localparam int          PVSC_LATCH_COUNT     = 6;
    localparam int          PVSC_LF_MISSING_SFD  = 0;
    localparam int          PVSC_LF_CODE_VIOL    = 1;
    localparam int          PVSC_LF_LINK_DROP    = 2;
    localparam int          PVSC_LF_UNLOCKED     = 3;
    localparam int          PVSC_LF_FALSE_CARR   = 4;
    localparam int          PVSC_LF_JAM          = 5;

    // ========================================
    // Error code put on the receive nibble lines after a code violation at 10 Mbit/s
    localparam logic [3:0]  PVSC_CODE_VIOL_NIBBLE = 4'h1;

    // Width of the synchronised level bundle
    localparam int          PVSC_SYNC_WIDTH      = 37;

endpackage

// *** verilog/pvsc_latch_bank.sv ***
// Bank of latch-high flags cleared by a register read.
// Assumes set pulses and the clear strobe are on i_clock.
`timescale 1ns/10ps

module pvsc_latch_bank
    import pvsc_pkg::*;
#(
    parameter int WIDTH = PVSC_LATCH_COUNT
)
(
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rst_b,
    // Flag control
    input  wire logic [WIDTH-1:0] i_set,
    input  wire logic             i_clear,
    // Flag view
    output logic      [WIDTH-1:0] o_flags
);

    logic [WIDTH-1:0] next_flags;

    // ========================================
    // Flag update
    // A set in the clearing cycle survives, so no event slips past a read
    always_comb
    begin
        next_flags = (i_clear ? '0 : o_flags) | i_set;
    end

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_flags <= '0;
        else
            o_flags <= next_flags;
    end

    // ========================================
    // Checks
    set_wins_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (i_set != '0) |=> ((o_flags & $past(i_set)) == $past(i_set)))
        else $error("latched flag lost its set event");

    flag_holds_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (!i_clear && (o_flags != '0)) |=> ((o_flags & $past(o_flags)) == $past(o_flags)))
        else $error("latched flag dropped without a read");

endmodule

// *** test/pvsc_mgmt_model.sv ***
// Management controller model: register reads and writes on the parallel port.
// Assumes the bench pops exp_q when o_rd_taken is high, one cycle after a read.
`timescale 1ns/10ps

module pvsc_mgmt_model
(
    // Clock
    input  wire logic        i_clock,
    // Register access
    output logic      [4:0]  o_reg_addr,
    output logic             o_reg_wr,
    output logic             o_reg_rd,
    output logic      [15:0] o_reg_wdata,
    // Read data due this cycle
    output logic             o_rd_taken
);
    logic [15:0] exp_q[$];

    // ==========
    // Idle state
    initial
    begin
        o_reg_addr  = 5'h00;
        o_reg_wr    = 1'b0;
        o_reg_rd    = 1'b0;
        o_reg_wdata = 16'h0000;
    end

    // Read data is registered, so it is due one edge after the taking edge
    always @(posedge i_clock)
        o_rd_taken <= o_reg_rd;

    // Released lines show the inverse, so a stale address never decodes by luck
    task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
        @(posedge i_clock);
        o_reg_addr  <= a;
        o_reg_wdata <= d;
        o_reg_wr    <= 1'b1;
        @(posedge i_clock);
        o_reg_wr    <= 1'b0;
        o_reg_addr  <= ~a;
        o_reg_wdata <= ~d;
    endtask

    task automatic reg_read(input logic [4:0] a, input logic [15:0] e);
        @(posedge i_clock);
        o_reg_addr <= a;
        o_reg_rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge i_clock);
        o_reg_rd   <= 1'b0;
        o_reg_addr <= ~a;
    endtask
endmodule

// *** test/pvsc_top_tb.sv ***
// Testbench for the vendor register bank: views, user word, counter, status flags.
// Assumes a 20 MHz clock and event pulses one cycle wide on that clock.
`timescale 1ns/10ps

module pvsc_top_tb;
    import pvsc_pkg::*;

    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [12:0] arb = '0;
    logic [3:0]  busy = '0;
    logic [2:0]  flprx = '0;
    logic [5:0]  nlp = '0;
    logic [5:0]  tx = '0;
    logic        spd = 1'b0;
    logic        fup = 1'b0;
    logic        sup = 1'b0;
    logic        prev = 1'b0;
    logic        pfix = 1'b0;
    logic [6:0]  ev = '0;
    logic        raw = 1'b0;
    logic [3:0]  nib = '0;
    logic [4:0]  addr;
    logic        wr;
    logic        rd;
    logic        taken;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [15:0] uword;
    logic [3:0]  nlines;
    logic        cbit;
    logic [15:0] d;
    int          num_errors = 0;
    int          tests_run = 0;
    int          n;

    always #25 clk = ~clk;

    pvsc_mgmt_model mgmt (.i_clock(clk), .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_rd(rd),
                          .o_reg_wdata(wdata), .o_rd_taken(taken));

    pvsc_top dut (.i_clock(clk), .i_rst_b(rst_b), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_arb_states(arb), .i_flp_rx_busy_states(busy),
        .i_flp_rx_states(flprx), .i_nlp_rx_states(nlp), .i_flp_tx_states(tx), .i_speed_100(spd),
        .i_fast_link_up(fup), .i_slow_link_up(sup), .i_polarity_reversed(prev),
        .i_polarity_fix_enable(pfix), .i_rx_error_event(ev[0]), .i_false_carrier_event(ev[1]),
        .i_link_drop_event(ev[2]), .i_missing_sfd_event(ev[3]), .i_code_violation_event(ev[4]),
        .i_scrambler_unlock_event(ev[5]), .i_jam_event(ev[6]), .i_rx_raw_bit(raw), .i_rx_nibble(nib),
        .o_rx_corrected_bit(cbit), .o_rx_nibble_lines(nlines), .o_user_word_bus(uword));

    // ==========
    // Shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle event pulses, bit order rx err, false carrier, drop, sfd, code, unlock, jam
    task automatic pulse(input logic [6:0] v);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= 7'h00;
    endtask

    // Levels pass two sync stages, so give them four edges
    task automatic settle();
        repeat (4) @(posedge clk);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Read data checker: oldest noted expectation against the settled read word
    always @(posedge clk)
    begin
        if (taken === 1'b1)
            chk(rdata, mgmt.exp_q.pop_front());
    end

    // Watchdog well past the expected run of about seven hundred cycles
    initial
    begin
        repeat (8000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end

    // ==========
    // Main sequence
    initial
    begin
        void'($urandom(32'h067d));
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        nib   <= 4'($urandom);
        mgmt.reg_read(PVSC_ADDR_ERR_COUNT, 16'h0000);
        mgmt.reg_read(PVSC_ADDR_STATUS, 16'h0000);
        mgmt.reg_read(5'h00, 16'h0000);
        // User word: bus follows each write, and reads back
        for (int i = 0; i < 4; i++)
        begin
            d = 16'($urandom);
            mgmt.reg_write(PVSC_ADDR_USER_WORD, d);
            #1 chk(uword, d);
            mgmt.reg_read(PVSC_ADDR_USER_WORD, d);
        end
        // State views, every receive busy state alone and none
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk);
            busy  <= 4'h8 >> i;
            arb   <= 13'($urandom);
            flprx <= 3'($urandom);
            nlp   <= 6'($urandom);
            tx    <= 6'($urandom);
            settle();
            mgmt.reg_write(PVSC_ADDR_PULSE_VIEW, 16'hffff);
            mgmt.reg_read(PVSC_ADDR_PULSE_VIEW, {|busy, flprx, nlp, tx});
            mgmt.reg_read(PVSC_ADDR_ARB_VIEW, {3'h0, arb});
        end
        // Whole-word mode: only receive errors count, count bits not writable
        mgmt.reg_write(PVSC_ADDR_ERR_COUNT, 16'hfffe);
        n = 1 + ($urandom % 20);
        repeat (n) pulse(7'h07);
        mgmt.reg_read(PVSC_ADDR_ERR_COUNT, 16'(n));
        fork
            mgmt.reg_read(PVSC_ADDR_ERR_COUNT, 16'h0000);
            pulse(7'h01);
        join
        mgmt.reg_read(PVSC_ADDR_ERR_COUNT, 16'h0001);
        mgmt.reg_read(PVSC_ADDR_ERR_COUNT, 16'h0000);
        // Split mode: three fields, receive error and false carrier fields wrap without carry
        mgmt.reg_write(PVSC_ADDR_ERR_COUNT, 16'h0001);
        for (int i = 0; i < 18; i++)
            pulse({4'h0, i < 5, 2'h3});
        mgmt.reg_read(PVSC_ADDR_ERR_COUNT, 16'h5212);
        repeat (257) pulse(7'h01);
        mgmt.reg_read(PVSC_ADDR_ERR_COUNT, 16'h0001);
        mgmt.reg_read(PVSC_ADDR_ERR_COUNT, 16'h0000);
        // Slow mode flags, fast mode events ignored
        @(posedge clk);
        sup  <= 1'b1;
        prev <= 1'b1;
        pfix <= 1'b1;
        raw  <= 1'b1;
        settle();
        #1 chk({15'h0, cbit}, 16'h0000);
        pulse(7'h78);
        #1 chk({12'h0, nlines}, 16'h0001);
        @(posedge clk);
        #1 chk({12'h0, nlines}, {12'h0, nib});
        mgmt.reg_read(PVSC_ADDR_STATUS, 16'h01c1);
        mgmt.reg_read(PVSC_ADDR_STATUS, 16'h0041);
        // Fast mode flags, slow mode events ignored, set during a clearing read kept
        @(posedge clk);
        spd  <= 1'b1;
        fup  <= 1'b1;
        sup  <= 1'b0;
        pfix <= 1'b0;
        settle();
        #1 chk({15'h0, cbit}, 16'h0001);
        pulse(7'h7e);
        fork
            mgmt.reg_read(PVSC_ADDR_STATUS, 16'h003e);
            pulse(7'h40);
        join
        mgmt.reg_read(PVSC_ADDR_STATUS, 16'h0006);
        mgmt.reg_read(PVSC_ADDR_STATUS, 16'h0002);
        // Reset in mid-run clears flags and user word
        pulse(7'h40);
        @(posedge clk);
        rst_b <= 1'b0;
        @(posedge clk);
        rst_b <= 1'b1;
        settle();
        mgmt.reg_read(PVSC_ADDR_STATUS, 16'h0002);
        mgmt.reg_read(PVSC_ADDR_USER_WORD, 16'h0000);
        repeat (2) @(posedge clk);
        report_and_stop();
    end
endmodule
